// *** common/sdadc_pkg.sv ***
package sdadc_pkg;

    // Channel, trigger and result widths
    localparam int NUM_CH  = 32;
    localparam int CH_W    = 5;
    localparam int TRIG_W  = 6;
    localparam int TRIG_N  = 64;
    localparam int RES_W   = 16;
    localparam int PGA_W   = 12;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_AW    = 2;

    // Trigger source codes: GPIO A 0..31, GPIO B 32..34, then these
    localparam logic [TRIG_W-1:0] TRIG_GPIOB0 = 6'h20;
    localparam logic [TRIG_W-1:0] TRIG_SW     = 6'h23;
    localparam logic [TRIG_W-1:0] TRIG_RNG    = 6'h24;
    localparam logic [TRIG_W-1:0] TRIG_PWM0   = 6'h26;
    localparam logic [TRIG_W-1:0] TRIG_TMR0   = 6'h30;

    // Sequencing mode bit positions
    localparam int MODE_CONV_POS = 1;  // 1 single, 0 continuous
    localparam int MODE_SCAN_POS = 0;  // 1 sweep all enabled channels

    // Status flag and interrupt enable bit positions
    localparam int FLG_IRQ  = 0;
    localparam int FLG_RDY  = 1;
    localparam int FLG_WCMP = 2;
    localparam int FLG_OF   = 3;

    // Reset values
    localparam logic [3:0]        FLAGS_RST = 4'h0;
    localparam logic [CH_W-1:0]   CH_RST    = 5'h00;

    // PGA offset adjust coding
    localparam int PGA_STEP_MV  = 40;
    localparam int ADJ_HI_POS   = 5;
    localparam int ADJ_LO_MSB   = 3;

    // Decimation ratio codes and their sample counts
    typedef enum logic [2:0] {
        DEC_32  = 3'h1,
        DEC_64  = 3'h3,
        DEC_128 = 3'h5,
        DEC_256 = 3'h4
    } sdadc_dec_t;
    localparam logic [8:0] RATIO_32  = 9'h020;
    localparam logic [8:0] RATIO_64  = 9'h040;
    localparam logic [8:0] RATIO_128 = 9'h080;
    localparam logic [8:0] RATIO_256 = 9'h100;

    typedef enum logic [1:0] {
        VINN_VREF     = 2'h0,
        VINN_VREF_3Q  = 2'h1,
        VINN_VREF_1H  = 2'h2,
        VINN_AGND     = 2'h3
    } sdadc_vinn_t;

    typedef struct packed {
        sdadc_dec_t  decimation_ratio;
        sdadc_vinn_t negative_input_choice;
        logic        pga_offset_direction;  // 1 up, 0 down
        logic [5:0]  pga_offset_step;
    } sdadc_profile_t;

    typedef struct packed {
        logic signed [RES_W-1:0] window_high_threshold;
        logic signed [RES_W-1:0] window_low_threshold;
    } sdadc_window_t;

    typedef struct packed {
        logic [CH_W-1:0]         channel;
        sdadc_dec_t              ratio;
        logic                    vinn_apply;
        sdadc_vinn_t             vinn;
        logic signed [PGA_W-1:0] pga_offset_mv;
    } sdadc_front_t;

endpackage

// *** logic/sdadc_decim.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdadc_decim
    import sdadc_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              start_i,
    input  wire logic              abort_i,
    input  wire sdadc_dec_t        ratio_i,
    input  wire logic              bit_valid_i,
    input  wire logic              bit_i,
    output logic                   done_o,
    output logic signed [RES_W-1:0] result_o
);

    logic       busy_q, busy_d;
    logic [8:0] cnt_q, cnt_d;
    logic [8:0] ones_q, ones_d;
    logic [8:0] n_q, n_d;
    logic       done_d;
    logic signed [RES_W-1:0] res_d;

    // Counting filter: result is ones minus zeros over the window
    always_comb begin
        busy_d = busy_q;
        cnt_d  = cnt_q;
        ones_d = ones_q;
        n_d    = n_q;
        done_d = 1'b0;
        res_d  = result_o;
        if (start_i) begin
            busy_d = 1'b1;
            cnt_d  = 9'h000;
            ones_d = 9'h000;
            case (ratio_i)
                DEC_32:  n_d = RATIO_32;
                DEC_64:  n_d = RATIO_64;
                DEC_128: n_d = RATIO_128;
                default: n_d = RATIO_256;
            endcase
        end else if (abort_i) begin
            busy_d = 1'b0;
        end else if (busy_q && bit_valid_i) begin
            cnt_d  = cnt_q + 9'h001;
            ones_d = ones_q + {8'h00, bit_i};
            if (cnt_d == n_q) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                res_d  = RES_W'({6'h00, ones_d, 1'b0})
                       - RES_W'({7'h00, n_q});
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_q   <= 1'b0;
            cnt_q    <= 9'h000;
            ones_q   <= 9'h000;
            n_q      <= RATIO_256;
            done_o   <= 1'b0;
            result_o <= 16'h0000;
        end else begin
            busy_q   <= busy_d;
            cnt_q    <= cnt_d;
            ones_q   <= ones_d;
            n_q      <= n_d;
            done_o   <= done_d;
            result_o <= res_d;
        end
    end

    a_ratio_count: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        done_o |-> $past(cnt_q) + 9'h001 == $past(n_q))
        else $error("decimator finished before its ratio");

endmodule
`default_nettype wire

// *** logic/sdadc_seq.sv ***
// Behaviour
// - Each bit of the channel select mask enables conversion of that channel.
// - A channel's profile bit picks settings set 0 when clear, set 1 when set.
// - Conversions start only from the one trigger source that is selected.
// - Single mode converts the lowest enabled channel once per start.
// - Continuous mode repeats the lowest enabled channel until disabled.
// - Single-scan converts every enabled channel in turn, then stops.
// - Continuous-scan sweeps enabled channels until the enable is cleared.
// - Mode bit 1 set means single, clear continuous; bit 0 enables scanning.
// - Each settings set picks a decimation ratio of 32, 64, 128 or 256.
// - The negative input choice applies only on single-ended channels.
// - PGA step zero disables adjust, else (b5+1)*(b3:0+1)*40 mV up or down.
// - Results are compared with signed 16-bit low and high thresholds.
// - A global mask enable plus enables for ready, window and overflow.
// - Flags for interrupt, ready, window and overflow are readable, cleared.
`timescale 1ns/1ps
`default_nettype none
module sdadc_seq
    import sdadc_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              conv_enable_i,
    input  wire logic [NUM_CH-1:0] channel_select_mask_i,
    input  wire logic [NUM_CH-1:0] channel_profile_select_i,
    input  wire logic [NUM_CH-1:0] single_ended_mask_i,
    input  wire logic [TRIG_W-1:0] trigger_choice_i,
    input  wire logic [1:0]        sequencing_mode_i,
    input  wire sdadc_profile_t    profile0_i,
    input  wire sdadc_profile_t    profile1_i,
    input  wire sdadc_window_t     window_i,
    input  wire logic [34:0]       gpio_trig_i,
    input  wire logic              sw_trig_i,
    input  wire logic              rng_trig_i,
    input  wire logic [9:0]        pwm_trig_i,
    input  wire logic [15:0]       timer_trig_i,
    input  wire logic              modulator_valid_i,
    input  wire logic              modulator_bit_i,
    input  wire logic              result_pop_i,
    input  wire logic [3:0]        irq_enable_i,
    input  wire logic [3:0]        flag_clear_i,
    output sdadc_front_t           front_cfg_o,
    output logic                   conv_busy_o,
    output logic [RES_W-1:0]       result_data_o,
    output logic                   result_valid_o,
    output logic [3:0]             status_o,
    output logic                   irq_o
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } sdadc_state_t;

    // Lowest set mask bit at or above from; MSB of the answer flags a hit
    function automatic logic [CH_W:0] seek(input logic [NUM_CH-1:0] m,
                                          input logic [CH_W:0] from);
        logic [CH_W:0] r;
        r = {1'b0, CH_RST};
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (m[i] && i >= int'(from)) begin
                r = {1'b1, CH_W'(i)};
            end
        end
        return r;
    endfunction

    // Front-end settings for a channel from its chosen profile
    function automatic sdadc_front_t make_cfg(input logic [CH_W-1:0] ch,
                                              input sdadc_profile_t p0,
                                              input sdadc_profile_t p1,
                                              input logic [NUM_CH-1:0] sel,
                                              input logic [NUM_CH-1:0] se);
        sdadc_front_t   c;
        sdadc_profile_t p;
        int             mag;
        p   = sel[ch] ? p1 : p0;
        mag = (int'(p.pga_offset_step[ADJ_HI_POS]) + 1)
            * (int'(p.pga_offset_step[ADJ_LO_MSB:0]) + 1) * PGA_STEP_MV;
        c.channel    = ch;
        c.ratio      = p.decimation_ratio;
        c.vinn_apply = se[ch];
        c.vinn       = se[ch] ? p.negative_input_choice : VINN_VREF;
        if (p.pga_offset_step == 6'h00) begin
            c.pga_offset_mv = 12'h000;
        end else if (p.pga_offset_direction) begin
            c.pga_offset_mv = PGA_W'(mag);
        end else begin
            c.pga_offset_mv = PGA_W'(-mag);
        end
        return c;
    endfunction

    sdadc_state_t            state_q, state_d;
    sdadc_front_t            cfg_d;
    logic                    trig_prev_q;
    logic                    trig_lvl, trig_edge;
    logic [TRIG_N-1:0]       trig_vec;
    logic [CH_W:0]           first_hit, after_hit, nxt_hit;
    logic                    go, start_go;
    logic                    mode_single, mode_scan;
    logic                    res_done;
    logic signed [RES_W-1:0] res_val;

    // Only the selected source is looked at; code 37 has no source
    assign trig_vec  = {timer_trig_i, pwm_trig_i, 1'b0, rng_trig_i,
                        sw_trig_i, gpio_trig_i};
    assign trig_lvl  = trig_vec[trigger_choice_i];
    assign trig_edge = trig_lvl & ~trig_prev_q;
    assign mode_single = sequencing_mode_i[MODE_CONV_POS];
    assign mode_scan   = sequencing_mode_i[MODE_SCAN_POS];

    // Sequencer: picks the next channel when a conversion finishes
    always_comb begin
        state_d   = state_q;
        cfg_d     = front_cfg_o;
        go        = 1'b0;
        start_go  = 1'b0;
        first_hit = seek(channel_select_mask_i, 6'h00);
        after_hit = seek(channel_select_mask_i,
                         {1'b0, front_cfg_o.channel} + 6'h01);
        nxt_hit   = first_hit;
        case (state_q)
            ST_IDLE: begin
                if (conv_enable_i && trig_edge && first_hit[CH_W]) begin
                    go       = 1'b1;
                    start_go = 1'b1;
                end
            end
            ST_CONV: begin
                if (!conv_enable_i) begin
                    state_d = ST_IDLE;
                end else if (res_done) begin
                    state_d = ST_IDLE;
                    if (mode_scan && after_hit[CH_W]) begin
                        go      = 1'b1;
                        nxt_hit = after_hit;
                    end else if (!mode_single && first_hit[CH_W]) begin
                        go = 1'b1;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (go) begin
            state_d = ST_CONV;
            cfg_d   = make_cfg(nxt_hit[CH_W-1:0], profile0_i, profile1_i,
                               channel_profile_select_i,
                               single_ended_mask_i);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q     <= ST_IDLE;
            front_cfg_o <= '0;
            trig_prev_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            front_cfg_o <= cfg_d;
            trig_prev_q <= trig_lvl;
        end
    end

    assign conv_busy_o = (state_q == ST_CONV);

    // Restarted on every channel, so each result uses its own ratio
    sdadc_decim u_decim (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .start_i     (go),
        .abort_i     (!conv_enable_i),
        .ratio_i     (cfg_d.ratio),
        .bit_valid_i (modulator_valid_i),
        .bit_i       (modulator_bit_i),
        .done_o      (res_done),
        .result_o    (res_val)
    );

    logic [RES_W-1:0]   mem_q [FIFO_DEPTH];
    logic [RES_W-1:0]   mem_d [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [FIFO_AW:0]   cnt_q, cnt_d;
    logic               full, accept, pop, in_window;

    assign full   = (cnt_q == (FIFO_AW + 1)'(FIFO_DEPTH));
    assign accept = res_done & ~full;
    assign pop    = result_pop_i & (cnt_q != 3'h0);

    // Result queue; a result arriving while full is dropped
    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (accept) begin
            mem_d[wr_q] = res_val;
            wr_d        = wr_q + 2'h1;
        end
        if (pop) begin
            rd_d = rd_q + 2'h1;
        end
        cnt_d = cnt_q + {2'h0, accept} - {2'h0, pop};
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                mem_q[i] <= 16'h0000;
            end
            wr_q  <= 2'h0;
            rd_q  <= 2'h0;
            cnt_q <= 3'h0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    assign result_data_o  = mem_q[rd_q];
    assign result_valid_o = (cnt_q != 3'h0);

    // Inclusive signed window
    assign in_window =
        (res_val >= window_i.window_low_threshold) &&
        (res_val <= window_i.window_high_threshold);

    logic [3:0] flags_d;
    logic       global_irq_mask_enable;
    assign global_irq_mask_enable = irq_enable_i[FLG_IRQ];

    // Ready, window and overflow flags sticky, a set in the clear cycle winning; interrupt flag follows them
    always_comb begin
        flags_d = status_o & ~flag_clear_i;
        if (accept) begin
            flags_d[FLG_RDY] = 1'b1;
        end
        if (res_done && in_window) begin
            flags_d[FLG_WCMP] = 1'b1;
        end
        if (res_done && full) begin
            flags_d[FLG_OF] = 1'b1;
        end
        flags_d[FLG_IRQ] = global_irq_mask_enable &&
            |(flags_d[FLG_OF:FLG_RDY] & irq_enable_i[FLG_OF:FLG_RDY]);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status_o <= FLAGS_RST;
        end else begin
            status_o <= flags_d;
        end
    end

    assign irq_o = status_o[FLG_IRQ];

    a_start_source: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_go |-> trig_lvl && !trig_prev_q && conv_enable_i)
        else $error("conversion started without selected trigger");

    a_first_channel: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_go |=> conv_busy_o &&
            front_cfg_o.channel == $past(first_hit[CH_W-1:0]))
        else $error("start did not pick lowest enabled channel");

    a_profile_pick: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_go |=> front_cfg_o.ratio == ($past(channel_profile_select_i[
            first_hit[CH_W-1:0]]) ? $past(profile1_i.decimation_ratio)
            : $past(profile0_i.decimation_ratio)))
        else $error("wrong settings set for channel");

    a_vinn_apply: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !front_cfg_o.vinn_apply |-> front_cfg_o.vinn == VINN_VREF)
        else $error("negative input used on differential channel");

    a_single_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        conv_busy_o && res_done && mode_single && !mode_scan
        |=> !conv_busy_o)
        else $error("single mode did not stop");

    a_burst_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        conv_busy_o && res_done && !mode_single && conv_enable_i
        && |channel_select_mask_i |=> conv_busy_o)
        else $error("continuous mode stopped while enabled");

    a_scan_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        conv_busy_o && res_done && mode_scan && conv_enable_i
        && after_hit[CH_W] |=> conv_busy_o &&
        front_cfg_o.channel > $past(front_cfg_o.channel))
        else $error("scan did not advance to higher channel");

    a_disable_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !conv_enable_i |=> !conv_busy_o)
        else $error("sequencer kept running after disable");

    a_overflow_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        res_done && full && !result_pop_i
        |=> status_o[FLG_OF] && cnt_q == $past(cnt_q))
        else $error("overflow not flagged or result stored");

    a_window_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        res_done && in_window |=> status_o[FLG_WCMP])
        else $error("in-window result did not set flag");

    a_irq_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !global_irq_mask_enable |=> !irq_o)
        else $error("interrupt raised with global enable clear");

endmodule
`default_nettype wire

// *** tb/test_sigma_delta_adc_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_sigma_delta_adc_sequencer
    import sdadc_pkg::*;
;
    // Stimulus registers, all but clk driven by non-blocking assignment
    logic              clk      = 1'h0;
    logic              rst      = 1'h1;
    logic              en       = 1'h0;
    logic [NUM_CH-1:0] mask     = '0;
    logic [NUM_CH-1:0] psel     = '0;
    logic [NUM_CH-1:0] se       = '0;
    logic [TRIG_W-1:0] trig     = TRIG_SW;
    logic [1:0]        mode     = 2'h2;
    sdadc_profile_t    p0       = '0;
    sdadc_profile_t    p1       = '0;
    sdadc_window_t     win      = '0;
    logic [34:0]       gpio     = '0;
    logic              sw       = 1'h0;
    logic              rng      = 1'h0;
    logic [9:0]        pwm      = '0;
    logic [15:0]       tmr      = '0;
    logic              mval     = 1'h0;
    logic              mbit     = 1'h0;
    logic              pop      = 1'h0;
    logic [3:0]        irq_en   = 4'h0;
    logic [3:0]        fclr     = 4'h0;
    sdadc_front_t      front;
    logic              busy;
    logic [RES_W-1:0]  rdata;
    logic              rvalid;
    logic [3:0]        status;
    logic              irq;
    int                mismatches = 0;
    int                cmp_count  = 0;
    int                cycles     = 0;
    int                n;
    // One entry per trigger kind: gpio A, gpio B, software, rng, pwm, timer
    int                codes[6] = '{5, 32, 35, 36, 47, 48};
    logic [5:0]        steps[6] = '{6'h00, 6'h23, 6'h0F, 6'h3F, 6'h10, 6'h21};
    sdadc_dec_t        decs[4]  = '{DEC_32, DEC_64, DEC_128, DEC_256};
    // Offset in mV that each steps entry should give, with its direction
    int                mvs[6]   = '{0, 320, -640, 1280, -40, 160};

    sdadc_seq sdadc_seq_i (
        .ref_clk_i                (clk),
        .rst_i                    (rst),
        .conv_enable_i            (en),
        .channel_select_mask_i    (mask),
        .channel_profile_select_i (psel),
        .single_ended_mask_i      (se),
        .trigger_choice_i         (trig),
        .sequencing_mode_i        (mode),
        .profile0_i               (p0),
        .profile1_i               (p1),
        .window_i                 (win),
        .gpio_trig_i              (gpio),
        .sw_trig_i                (sw),
        .rng_trig_i               (rng),
        .pwm_trig_i               (pwm),
        .timer_trig_i             (tmr),
        .modulator_valid_i        (mval),
        .modulator_bit_i          (mbit),
        .result_pop_i             (pop),
        .irq_enable_i             (irq_en),
        .flag_clear_i             (fclr),
        .front_cfg_o              (front),
        .conv_busy_o              (busy),
        .result_data_o            (rdata),
        .result_valid_o           (rvalid),
        .status_o                 (status),
        .irq_o                    (irq)
    );

    // Clock at 25 MHz
    always #20 clk = ~clk;

    // Hang guard: a run of this length needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Step past edges, then let that edge's updates land before sampling
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Drives the source line that a trigger code selects
    task automatic set_src(input int c, input logic v);
        if (c < 35) gpio[c] <= v;
        else if (c == 35) sw <= v;
        else if (c == 36) rng <= v;
        else if (c < 48) pwm[c-38] <= v;
        else tmr[c-48] <= v;
    endtask

    // One-cycle pulse; the start is taken at the second edge
    task automatic pulse(input int c);
        @(posedge clk);
        set_src(c, 1'h1);
        @(posedge clk);
        set_src(c, 1'h0);
        #1;
    endtask

    // Feeds k modulator bits, the first "ones" of them high, then waits
    // the done edge and the queue edge
    task automatic feed(input int k, input int ones);
        for (int b = 0; b < k; b++) begin
            @(posedge clk);
            mval <= 1'h1;
            mbit <= (b < ones);
        end
        @(posedge clk);
        mval <= 1'h0;
        tick(1);
    endtask

    task automatic pop_one();
        @(posedge clk);
        pop <= 1'h1;
        @(posedge clk);
        pop <= 1'h0;
        #1;
    endtask

    // Pops until empty, bounded; returns how many results were queued
    task automatic drain(output int cnt);
        cnt = 0;
        while (rvalid === 1'h1 && cnt < 8) begin
            pop_one();
            cnt++;
        end
    endtask

    task automatic set_en(input logic v);
        @(posedge clk);
        en <= v;
        tick(1);
    endtask

    task automatic clear_flags();
        @(posedge clk);
        fclr <= 4'hE;
        @(posedge clk);
        fclr <= 4'h0;
        #1;
    endtask

    // Front-end settings expected for a channel using profile p
    function automatic sdadc_front_t exp_front(input int ch,
                                               input sdadc_profile_t p,
                                               input logic s);
        sdadc_front_t f;
        int           mv;
        mv = (int'(p.pga_offset_step[5]) + 1)
           * (int'(p.pga_offset_step[3:0]) + 1) * PGA_STEP_MV;
        if (p.pga_offset_step == 6'h00) mv = 0;
        if (!p.pga_offset_direction) mv = -mv;
        f.channel       = CH_W'(ch);
        f.ratio         = p.decimation_ratio;
        f.vinn_apply    = s;
        f.vinn          = s ? p.negative_input_choice : VINN_VREF;
        f.pga_offset_mv = PGA_W'(mv);
        return f;
    endfunction

    task automatic t_reset();
        chk("busy", busy, 0);
        chk("front", 32'(front), 0);
        chk("valid", rvalid, 0);
        chk("status", status, 0);
        chk("irq", irq, 0);
    endtask

    // Every trigger kind, each refusing a wrong source; aborts by disable
    task automatic t_triggers();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            trig <= TRIG_W'(codes[i]);
            p0   <= '{decs[i%4], sdadc_vinn_t'(i%4), i[0], steps[i]};
            en   <= 1'h1;
            pulse(codes[(i+1)%6]);
            chk("busy wrong src", busy, 0);
            pulse(codes[i]);
            chk("busy", busy, 1);
            chk("front", 32'(front), 32'(exp_front(9, p0, 1'h1)));
            chk("pga", {20'h00000, front.pga_offset_mv},
                {20'h00000, PGA_W'(mvs[i])});
            set_en(1'h0);
            chk("busy abort", busy, 0);
            chk("valid abort", rvalid, 0);
        end
    endtask

    // Single on the lowest channel; result on the inclusive high bound
    task automatic t_single();
        @(posedge clk);
        trig   <= TRIG_SW;
        psel   <= 32'h0000_0200;
        mode   <= 2'h2;
        irq_en <= 4'h2;
        en     <= 1'h1;
        pulse(35);
        chk("front", 32'(front), 32'(exp_front(9, p1, 1'h1)));
        feed(32, 26);
        chk("busy", busy, 0);
        chk("data", rdata, 16'h0014);
        chk("status", status, 4'h6);
        chk("irq masked", irq, 0);
        @(posedge clk);
        irq_en <= 4'h3;
        tick(2);
        chk("irq", irq, 1);
        chk("status", status, 4'h7);
        clear_flags();
        chk("status cleared", status, 4'h0);
        drain(n);
        chk("queued", n, 1);
    endtask

    // Continuous, single-scan and continuous-scan modes, checked in turn
    task automatic t_modes();
        @(posedge clk);
        mode <= 2'h0;
        pulse(35);
        feed(32, 16);
        chk("busy cont", busy, 1);
        chk("front cont", front.channel, 9);
        feed(32, 0);
        chk("head", rdata, 16'h0000);
        pop_one();
        chk("head next", rdata, 16'hFFE0);
        set_en(1'h0);
        chk("busy off", busy, 0);
        drain(n);
        @(posedge clk);
        mode <= 2'h3;
        en   <= 1'h1;
        pulse(35);
        feed(32, 16);
        chk("front scan", 32'(front), 32'(exp_front(20, p0, 1'h0)));
        feed(64, 32);
        chk("busy scan", busy, 0);
        drain(n);
        chk("scan count", n, 2);
        @(posedge clk);
        mode <= 2'h1;
        pulse(35);
        feed(32, 16);
        feed(64, 32);
        chk("front sweep", front.channel, 9);
        chk("busy sweep", busy, 1);
        set_en(1'h0);
        chk("busy sweep off", busy, 0);
        drain(n);
        chk("sweep count", n, 2);
    endtask

    // Five results into a four-deep queue, all below the window
    task automatic t_overflow();
        clear_flags();
        @(posedge clk);
        mode   <= 2'h0;
        mask   <= 32'h0000_0200;
        irq_en <= 4'h9;
        en     <= 1'h1;
        pulse(35);
        repeat (4) feed(32, 0);
        chk("no overflow", status[FLG_OF], 0);
        feed(32, 0);
        chk("overflow", status[FLG_OF], 1);
        chk("window miss", status[FLG_WCMP], 0);
        chk("irq overflow", irq, 1);
        set_en(1'h0);
        drain(n);
        chk("kept", n, FIFO_DEPTH);
    endtask

    initial begin
        // Channel 9 stays on set 0 until the single test, so the trigger
        // loop sees its own settings
        mask <= 32'h0010_0200;
        se   <= 32'h0000_0200;
        p1   <= '{DEC_32, VINN_VREF_1H, 1'h1, 6'h23};
        win  <= '{16'h0014, 16'hFFF6};
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        tick(1);
        t_reset();
        t_triggers();
        @(posedge clk);
        p0 <= '{DEC_64, VINN_AGND, 1'h0, 6'h00};
        t_single();
        t_modes();
        t_overflow();
        final_report();
    end
endmodule
`default_nettype wire
